// file: verilog/crs_pkg.sv
// Shared constants and types of the core regulator sequencer.
package crs_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_MIN_US = 3000;
  localparam int SETTLE_MAX_US = 12000;
  localparam int BOOT_STEP_US = 200;
  localparam int RUN_STEP_US = 140;
  localparam int PG_DELAY_US = 1000;
  localparam int SETTLE_MIN_CYC = SETTLE_MIN_US * CLK_MHZ;
  localparam int SETTLE_MAX_CYC = SETTLE_MAX_US * CLK_MHZ;
  localparam int BOOT_STEP_CYC = BOOT_STEP_US * CLK_MHZ;
  localparam int RUN_STEP_CYC = RUN_STEP_US * CLK_MHZ;
  localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int CODE_W = 6;
  localparam int PWM_PERIOD = 500;
  localparam int PWM_W = 9;
  localparam logic [CODE_W-1:0] REF_START = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CODES = 12'h008;
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_FORCE_ONE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_POR_OK = 3;
  localparam int ST_UV = 4;
  localparam int ST_FAULT = 5;
  localparam int ST_OV = 6;
  localparam int ST_PG = 7;
  localparam int ST_TWO_CH = 8;
  localparam int ST_DEEP = 9;
  localparam int ST_DEEPER = 10;
  localparam int CODES_TARGET = 8;
  localparam int CODES_VID = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CRS_OFF = 3'b000,
    CRS_SOFT = 3'b001,
    CRS_BOOT_WAIT = 3'b010,
    CRS_CAPTURE = 3'b011,
    CRS_RUN = 3'b100,
    CRS_FAULT = 3'b101
  } crs_state_e;
endpackage : crs_pkg

// file: verilog/crs_drive_if.sv
// Bundle between the sequencer and its two-phase gate-drive generator.
`timescale 1ns/1ps
interface crs_drive_if #(parameter int DUTY_W = 9);
  logic enable;
  logic two_ch;
  logic [DUTY_W-1:0] duty;
  logic [1:0] high_side;
  logic [1:0] low_side;
  logic [1:0] oe_n;
  modport ctrl (output enable, output two_ch, output duty,
    input high_side, input low_side, input oe_n);
  modport gen (input enable, input two_ch, input duty,
    output high_side, output low_side, output oe_n);
endinterface : crs_drive_if

// file: verilog/crs_phase_gen.sv
// Two-channel gate-drive generator with channels half a period apart.
`timescale 1ns/1ps
module crs_phase_gen #(
  parameter int PERIOD = crs_pkg::PWM_PERIOD,
  parameter int PWM_W = crs_pkg::PWM_W
) (
  input wire logic clock,
  input wire logic nrst,
  crs_drive_if.gen drv
);
  import crs_pkg::*;
  localparam logic [PWM_W-1:0] LAST = PWM_W'(PERIOD - 1);
  localparam logic [PWM_W-1:0] HALF = PWM_W'(PERIOD / 2);
  logic [PWM_W-1:0] cnt_q;
  logic [PWM_W-1:0] cnt2;

  initial
  begin
    if (PERIOD < 4 || PERIOD > (1 << PWM_W))
      $error("crs_phase_gen: PERIOD does not fit PWM_W");
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= '0;
    else if (!drv.enable || cnt_q == LAST)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  always_comb
  begin
    if (cnt_q >= HALF)
      cnt2 = cnt_q - HALF;
    else
      cnt2 = cnt_q + (LAST - HALF) + 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      drv.high_side <= 2'h0;
      drv.low_side <= 2'h0;
      drv.oe_n <= 2'h3;
    end
    else
    begin
      drv.high_side[0] <= drv.enable && cnt_q < drv.duty;
      drv.low_side[0] <= drv.enable && !(cnt_q < drv.duty);
      drv.oe_n[0] <= !drv.enable; // see R1
      drv.high_side[1] <= drv.enable && drv.two_ch && cnt2 < drv.duty; // see R19
      drv.low_side[1] <= drv.enable && drv.two_ch && !(cnt2 < drv.duty);
      drv.oe_n[1] <= !(drv.enable && drv.two_ch); // see R11
    end
  end
endmodule : crs_phase_gen

// file: verilog/crs_sequencer.sv
// Sequencer, protection and AXI4-Lite registers of the core regulator.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// R1 - Gate drives high impedance until supply good.
// R2 - Supply falling threshold forces drives to high impedance.
// R3 - Enable high after supply good starts soft start.
// R4 - Undervoltage or overcurrent latch cleared by enable low.
// R5 - Overvoltage latch cleared only by supply reset.
// R6 - Start-up regulates to the boot setpoint.
// R7 - After companion good, capture code, settle 3-12 ms.
// R8 - Power good is input; hold boot until high.
// R9 - After start-up pull power good low outside limits.
// R10 - Power good asserted after a delay timer.
// R11 - Channel select high runs two channels, else one.
// R12 - Deep-sleep input low enters deep sleep.
// R13 - Deeper-sleep input high enters deeper sleep.
// R14 - Target follows mode: deep or deeper setpoint.
// R15 - Voltage code is six bits, bit zero lowest.
// R16 - Undervoltage set below 84 %, cleared above 85 %.
// R17 - Overvoltage flagged above 112 % of setpoint.
// R18 - Power good masked while target transitions.
// R19 - Two channels switch 180 degrees apart.
// R20 - All pin inputs synchronised before use; pwm_duty goes to the generator unsynchronised.
module crs_sequencer #(
  parameter int SETTLE_MIN = crs_pkg::SETTLE_MIN_CYC,
  parameter int SETTLE_MAX = crs_pkg::SETTLE_MAX_CYC,
  parameter int BOOT_STEP = crs_pkg::BOOT_STEP_CYC,
  parameter int RUN_STEP = crs_pkg::RUN_STEP_CYC,
  parameter int PG_DELAY = crs_pkg::PG_DELAY_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supply_above_rising,
  input wire logic supply_below_falling,
  input wire logic system_regulator_on,
  input wire logic channel_count_select,
  input wire logic deep_sleep_enable_n,
  input wire logic deeper_sleep_enable,
  input wire logic [crs_pkg::CODE_W-1:0] voltage_code,
  input wire logic [crs_pkg::CODE_W-1:0] boot_setpoint_input,
  input wire logic [crs_pkg::CODE_W-1:0] deep_sleep_setpoint_input,
  input wire logic [crs_pkg::CODE_W-1:0] deeper_sleep_setpoint_input,
  input wire logic sense_below_uv_fall,
  input wire logic sense_above_uv_rise,
  input wire logic sense_above_ov,
  input wire logic overcurrent_trip,
  input wire logic [crs_pkg::PWM_W-1:0] pwm_duty,
  input wire logic power_good_i,
  output logic power_good_o,
  output logic power_good_oe_n,
  output logic high_side_drive_ch1,
  output logic low_side_drive_ch1,
  output logic drive_oe_n_ch1,
  output logic high_side_drive_ch2,
  output logic low_side_drive_ch2,
  output logic drive_oe_n_ch2,
  output logic [crs_pkg::CODE_W-1:0] reference_code,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import crs_pkg::*;
  localparam int SYNC_W = 9 + 4 * CODE_W;

  initial
  begin
    if (SETTLE_MIN < 1 || RUN_STEP < 1 || BOOT_STEP < 1 || PG_DELAY < 1 ||
        SETTLE_MIN >= (1 << CNT_W) || PG_DELAY >= (1 << CNT_W) ||
        BOOT_STEP >= (1 << CNT_W) ||
        SETTLE_MIN + int'(CODE_MAX) * RUN_STEP > SETTLE_MAX)
      $error("crs_sequencer: timing parameters out of range");
  end

  logic [SYNC_W-1:0] raw, meta_q, sync_q;
  logic por_rise, por_fall, en, two_sel, deep, deeper, pg_in;
  logic uv_fall, uv_rise, ov_in, oc_in;
  logic [CODE_W-1:0] vid, boot_sp, deep_sp, deeper_sp;

  assign raw = {supply_above_rising, supply_below_falling,
    system_regulator_on, channel_count_select, deep_sleep_enable_n,
    deeper_sleep_enable, power_good_i, sense_above_ov, overcurrent_trip,
    voltage_code, boot_setpoint_input, deep_sleep_setpoint_input,
    deeper_sleep_setpoint_input};

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw; // see R20
      sync_q <= meta_q;
    end
  end

  logic [1:0] uv_meta_q, uv_sync_q;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      uv_meta_q <= 2'h0;
      uv_sync_q <= 2'h0;
    end
    else
    begin
      uv_meta_q <= {sense_below_uv_fall, sense_above_uv_rise};
      uv_sync_q <= uv_meta_q;
    end
  end

  assign {por_rise, por_fall, en, two_sel} = sync_q[SYNC_W-1 -: 4];
  assign deep = !sync_q[SYNC_W-5]; // see R12
  assign deeper = sync_q[SYNC_W-6]; // see R13
  assign {pg_in, ov_in, oc_in} = sync_q[SYNC_W-7 -: 3];
  assign vid = sync_q[4*CODE_W-1 -: CODE_W]; // see R15
  assign boot_sp = sync_q[3*CODE_W-1 -: CODE_W];
  assign deep_sp = sync_q[2*CODE_W-1 -: CODE_W];
  assign deeper_sp = sync_q[CODE_W-1:0];
  assign {uv_fall, uv_rise} = uv_sync_q;

  crs_state_e state_q;
  logic por_ok_q, fault_q, ov_q, uv_q, pg_ok_q;
  logic [1:0] ctrl_q;
  logic [CODE_W-1:0] ref_q, vid_q, target;
  logic [CNT_W-1:0] step_q, wait_q;
  logic step, active, go, moving;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      por_ok_q <= 1'b0;
    else if (por_fall)
      por_ok_q <= 1'b0; // see R2
    else if (por_rise)
      por_ok_q <= 1'b1; // see R1
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      uv_q <= 1'b0;
    else if (uv_fall)
      uv_q <= 1'b1; // see R16
    else if (uv_rise)
      uv_q <= 1'b0; // see R16
  end

  assign active = state_q == CRS_SOFT || state_q == CRS_BOOT_WAIT ||
    state_q == CRS_CAPTURE || state_q == CRS_RUN;
  assign go = por_ok_q && en && ctrl_q[CTRL_SW_EN];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      fault_q <= 1'b0;
    else if (active && (oc_in || (state_q == CRS_RUN && uv_q)))
      fault_q <= 1'b1; // see R4
    else if (!en)
      fault_q <= 1'b0; // see R4
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ov_q <= 1'b0;
    else if (active && ov_in)
      ov_q <= 1'b1; // see R17
    else if (!por_ok_q)
      ov_q <= 1'b0; // see R5
  end

  always_comb
  begin
    if (state_q != CRS_RUN)
      target = boot_sp; // see R6
    else if (deeper)
      target = deeper_sp; // see R14
    else if (deep)
      target = deep_sp; // see R14
    else
      target = vid_q;
  end
  assign moving = ref_q != target;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      step_q <= '0;
    else if (step || !active)
      step_q <= '0;
    else
      step_q <= step_q + 1'b1;
  end
  assign step = state_q == CRS_SOFT ? step_q == CNT_W'(BOOT_STEP - 1)
    : step_q == CNT_W'(RUN_STEP - 1);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ref_q <= REF_START;
    else if (state_q == CRS_OFF)
      ref_q <= REF_START;
    else if (active && step && moving && state_q != CRS_BOOT_WAIT)
      ref_q <= ref_q < target ? ref_q + 1'b1 : ref_q - 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      vid_q <= '0;
    else if (state_q == CRS_RUN || wait_q == CNT_W'(SETTLE_MIN - 1))
      vid_q <= vid; // see R7
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_q <= CRS_OFF;
    else if (!por_ok_q)
      state_q <= CRS_OFF; // see R2
    else if (active && (ov_in || oc_in || (state_q == CRS_RUN && uv_q)))
      state_q <= CRS_FAULT; // see R4
    else if (active && !go)
      state_q <= CRS_OFF;
    else
    begin
      case (state_q)
        CRS_OFF:
          if (go && !fault_q && !ov_q)
            state_q <= CRS_SOFT; // see R3
        CRS_SOFT:
          if (!moving)
            state_q <= CRS_BOOT_WAIT;
        CRS_BOOT_WAIT:
          if (pg_in && !uv_q)
            state_q <= CRS_CAPTURE; // see R8
        CRS_CAPTURE:
          if (wait_q == CNT_W'(SETTLE_MIN - 1))
            state_q <= CRS_RUN; // see R7
        CRS_RUN:
          state_q <= CRS_RUN;
        CRS_FAULT:
          if (!en && !ov_q)
            state_q <= CRS_OFF; // see R4
        default:
          state_q <= CRS_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      wait_q <= '0;
    else if ((state_q == CRS_CAPTURE && wait_q != CNT_W'(SETTLE_MIN - 1)) ||
        (state_q == CRS_RUN && !moving && !uv_q && !ov_in && !pg_ok_q))
      wait_q <= wait_q + 1'b1;
    else
      wait_q <= '0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pg_ok_q <= 1'b0;
    else if (state_q != CRS_RUN)
      pg_ok_q <= 1'b0;
    else if (moving)
      pg_ok_q <= pg_ok_q; // see R18
    else if (uv_q || ov_in)
      pg_ok_q <= 1'b0; // see R9
    else if (wait_q == CNT_W'(PG_DELAY - 1))
      pg_ok_q <= 1'b1; // see R10
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      power_good_o <= 1'b0;
      power_good_oe_n <= 1'b1;
      reference_code <= REF_START;
    end
    else
    begin
      power_good_o <= 1'b0;
      power_good_oe_n <= !((state_q == CRS_RUN || state_q == CRS_FAULT) &&
        !pg_ok_q); // see R9
      reference_code <= ref_q;
    end
  end

  crs_drive_if #(.DUTY_W(PWM_W)) drv ();
  assign drv.enable = active && por_ok_q; // see R1
  assign drv.two_ch = two_sel && !ctrl_q[CTRL_FORCE_ONE]; // see R11
  assign drv.duty = pwm_duty;

  crs_phase_gen #(.PERIOD(PWM_PERIOD), .PWM_W(PWM_W)) u_gen (
    .clock(clock),
    .nrst(nrst),
    .drv(drv.gen)
  );
  assign high_side_drive_ch1 = drv.high_side[0];
  assign low_side_drive_ch1 = drv.low_side[0];
  assign drive_oe_n_ch1 = drv.oe_n[0];
  assign high_side_drive_ch2 = drv.high_side[1];
  assign low_side_drive_ch2 = drv.low_side[1];
  assign drive_oe_n_ch2 = drv.oe_n[1];

  logic aw_full_q, w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if (awaddr_q[11:2] == ADDR_CTRL[11:2])
        begin
          if (wstrb_q[0])
            ctrl_q <= wdata_q[1:0];
        end
        else if (awaddr_q[11:2] != ADDR_STATUS[11:2] &&
            awaddr_q[11:2] != ADDR_CODES[11:2])
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] status;
  always_comb
  begin
    status = '0;
    status[2:0] = state_q;
    status[ST_POR_OK] = por_ok_q;
    status[ST_UV] = uv_q;
    status[ST_FAULT] = fault_q;
    status[ST_OV] = ov_q;
    status[ST_PG] = pg_ok_q;
    status[ST_TWO_CH] = drv.two_ch;
    status[ST_DEEP] = deep;
    status[ST_DEEPER] = deeper;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (s_axi_araddr[11:2] == ADDR_CTRL[11:2])
        s_axi_rdata[1:0] <= ctrl_q;
      else if (s_axi_araddr[11:2] == ADDR_STATUS[11:2])
        s_axi_rdata <= status;
      else if (s_axi_araddr[11:2] == ADDR_CODES[11:2])
        s_axi_rdata <= {8'h00, 2'h0, vid_q, 2'h0, target, 2'h0, ref_q};
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : crs_sequencer

// file: testbench/crs_properties.sv
// Port checker of the core regulator sequencer.
`timescale 1ns/1ps
module crs_checker #(
  parameter int PG_DELAY = 10
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supply_above_rising,
  input wire logic supply_below_falling,
  input wire logic system_regulator_on,
  input wire logic channel_count_select,
  input wire logic sense_above_ov,
  input wire logic power_good_o,
  input wire logic power_good_oe_n,
  input wire logic high_side_drive_ch1,
  input wire logic high_side_drive_ch2,
  input wire logic drive_oe_n_ch1,
  input wire logic drive_oe_n_ch2,
  input wire logic [crs_pkg::CODE_W-1:0] reference_code
);
  import crs_pkg::*;
  logic seen_q;
  logic [3:0] ov_age_q;
  logic [7:0] still_q;
  logic hiz;
  assign hiz = drive_oe_n_ch1 && drive_oe_n_ch2;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) seen_q <= 1'b0;
    else if (supply_above_rising) seen_q <= 1'b1;
  end
  // Ages an overvoltage trip until a supply loss clears the latch.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) ov_age_q <= 4'h0;
    else if (supply_below_falling) ov_age_q <= 4'h0;
    else if (sense_above_ov && !drive_oe_n_ch1) ov_age_q <= 4'h1;
    else if (ov_age_q != 4'h0 && ov_age_q != 4'h8) ov_age_q <= ov_age_q + 4'h1;
  end
  // Counts cycles with an unchanged reference.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) still_q <= 8'h0;
    else if ($changed(reference_code)) still_q <= 8'h0;
    else if (still_q != 8'hff) still_q <= still_q + 8'h1;
  end
  a_hiz_before_supply: assert property (
    !hiz |-> seen_q) else $error("drive enabled before supply good");
  a_hiz_on_loss: assert property (
    supply_below_falling |-> ##[1:6] hiz) else $error("drive on after loss");
  a_off_no_enable: assert property (
    !system_regulator_on [*5] |-> hiz) else $error("drive on while disabled");
  a_ov_trip: assert property (
    sense_above_ov && !hiz |-> ##[1:6] hiz) else $error("no overvoltage trip");
  a_ov_latch_holds: assert property (
    ov_age_q == 4'h8 |-> hiz) else $error("overvoltage latch released");
  a_ref_one_step: assert property (
    !$past(drive_oe_n_ch1) && !drive_oe_n_ch1 && $changed(reference_code)
    |-> (reference_code - $past(reference_code)) == 6'h01
    || ($past(reference_code) - reference_code) == 6'h01)
    else $error("reference jumped");
  a_pg_open_drain: assert property (
    !power_good_oe_n |-> !power_good_o) else $error("power good driven high");
  a_pg_after_delay: assert property (
    $rose(power_good_oe_n) && !drive_oe_n_ch1 |-> still_q >= PG_DELAY - 1)
    else $error("power good released early");
  a_one_channel: assert property (
    !channel_count_select [*4] |-> drive_oe_n_ch2)
    else $error("second channel on");
  a_half_period: assert property (
    $rose(high_side_drive_ch1) && !drive_oe_n_ch2
    |-> ##[248:252] ($rose(high_side_drive_ch2) || drive_oe_n_ch2))
    else $error("channels not half a period apart");
  c_pg_release: cover property ($rose(power_good_oe_n) && !drive_oe_n_ch1);
  c_ov_latched: cover property (ov_age_q == 4'h8);
  c_two_channel: cover property (!drive_oe_n_ch2);
endmodule : crs_checker
bind crs_sequencer crs_checker #(.PG_DELAY(PG_DELAY)) u_crs_chk (
  .clock, .nrst, .supply_above_rising, .supply_below_falling,
  .system_regulator_on, .channel_count_select, .sense_above_ov,
  .power_good_o, .power_good_oe_n, .high_side_drive_ch1,
  .high_side_drive_ch2, .drive_oe_n_ch1, .drive_oe_n_ch2, .reference_code);

// file: testbench/crs_system_model.sv
// Companion regulators and the wired power-good pin.
`timescale 1ns/1ps
module crs_system_model #(
  parameter int DELAY = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic system_regulator_on,
  input wire logic hold_off,
  input wire logic power_good_o,
  input wire logic power_good_oe_n,
  output logic power_good_i
);
  logic [7:0] wait_q;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) wait_q <= 8'h0;
    else if (!system_regulator_on || hold_off) wait_q <= 8'h0;
    else if (wait_q != 8'hff) wait_q <= wait_q + 8'h1;
  end
  // The pin is pulled up and goes low when either party pulls it down.
  assign power_good_i = (wait_q > DELAY)
    && (power_good_oe_n || power_good_o);
endmodule : crs_system_model

// file: testbench/tb.sv
// Self-checking bench of the core regulator sequencer.
`timescale 1ns/1ps
module tb;
  import crs_pkg::*;
  typedef struct {logic dsn; logic drs; logic ch; logic [5:0] exp;} crs_row_s;
  localparam int SMIN = 40;
  localparam int SMAX = 300;
  localparam int PGD = 10;
  localparam logic [5:0] BOOT = 6'h20;
  localparam logic [5:0] CODE = 6'h23;
  logic clock = 1'b0, nrst = 1'b0, hold_off = 1'b1;
  logic supply_above_rising = 1'b0, supply_below_falling = 1'b0;
  logic system_regulator_on = 1'b0, channel_count_select = 1'b1;
  logic deep_sleep_enable_n = 1'b1, deeper_sleep_enable = 1'b0;
  logic [5:0] voltage_code = CODE, boot_setpoint_input = BOOT;
  logic [5:0] deep_sleep_setpoint_input = 6'h28;
  logic [5:0] deeper_sleep_setpoint_input = 6'h30;
  logic sense_below_uv_fall = 1'b0, sense_above_uv_rise = 1'b0;
  logic sense_above_ov = 1'b0, overcurrent_trip = 1'b0;
  logic [8:0] pwm_duty = 9'h064;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic power_good_i, power_good_o, power_good_oe_n;
  logic high_side_drive_ch1, low_side_drive_ch1, drive_oe_n_ch1;
  logic high_side_drive_ch2, low_side_drive_ch2, drive_oe_n_ch2;
  logic [5:0] reference_code;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, n_tests = 0, n, lows;
  crs_row_s rows [5] = '{'{1'b1, 1'b0, 1'b1, CODE}, '{1'b0, 1'b0, 1'b0, 6'h28},
    '{1'b0, 1'b1, 1'b0, 6'h30}, '{1'b1, 1'b1, 1'b1, 6'h30},
    '{1'b1, 1'b0, 1'b0, CODE}};
  crs_sequencer #(.SETTLE_MIN(SMIN), .SETTLE_MAX(SMAX), .BOOT_STEP(4),
    .RUN_STEP(2), .PG_DELAY(PGD)) DUT (.*);
  crs_system_model #(.DELAY(20)) u_sys (.*);
  initial
  begin
    forever #4 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // Waits for the reference and counts cycles with power good pulled low.
  task automatic wait_ref(input logic [5:0] e);
    n = 0;
    lows = 0;
    while (reference_code !== e && n < 3000)
    begin
      @(negedge clock);
      n++;
      if (power_good_oe_n !== 1'b1) lows++;
    end
  endtask : wait_ref
  task automatic cycle_en();
    system_regulator_on <= 1'b0;
    repeat (6) @(posedge clock);
    system_regulator_on <= 1'b1;
    repeat (10) @(negedge clock);
  endtask : cycle_en
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Allows about sixty times the expected run.
  initial
  begin
    #240000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk("drive_oe_n_ch1", drive_oe_n_ch1, 1'b1);
    chk("power_good_oe_n", power_good_oe_n, 1'b1);
    chk("reference_code", reference_code, REF_START);
    axr(ADDR_CTRL);
    chk("ctrl", d, CTRL_RESET);
    axr(12'h0f0);
    chk("rresp", r, RESP_SLVERR);
    axw(12'h0f0, 32'h0);
    chk("bresp", r, RESP_SLVERR);
    $display("test reset done");
    @(posedge clock);
    system_regulator_on <= 1'b1;
    repeat (20) @(negedge clock);
    chk("drive_oe_n_ch1", drive_oe_n_ch1, 1'b1);
    @(posedge clock);
    supply_above_rising <= 1'b1;
    wait_ref(BOOT);
    chk("boot ref", reference_code, BOOT);
    chk("boot ramp", n >= 31 * 4, 1'b1);
    @(posedge clock);
    sense_below_uv_fall <= 1'b1;
    repeat (4) @(posedge clock);
    sense_below_uv_fall <= 1'b0;
    hold_off <= 1'b0;
    repeat (60) @(negedge clock);
    chk("held ref", reference_code, BOOT);
    axr(ADDR_STATUS);
    chk("state", d[2:0], 3'h2);
    chk("uv flag", d[ST_UV], 1'b1);
    @(posedge clock);
    sense_above_uv_rise <= 1'b1;
    repeat (4) @(posedge clock);
    sense_above_uv_rise <= 1'b0;
    wait_ref(CODE);
    chk("run ref", reference_code, CODE);
    chk("settle", n >= SMIN && n <= SMAX, 1'b1);
    chk("pg early", power_good_oe_n, 1'b0);
    repeat (PGD + 8) @(negedge clock);
    chk("pg late", power_good_oe_n, 1'b1);
    $display("test bring-up done");
    foreach (rows[i])
    begin
      @(posedge clock);
      deep_sleep_enable_n <= rows[i].dsn;
      deeper_sleep_enable <= rows[i].drs;
      channel_count_select <= rows[i].ch;
      repeat (4) @(negedge clock);
      wait_ref(rows[i].exp);
      repeat (4) @(negedge clock);
      chk("mode ref", reference_code, rows[i].exp);
      chk("pg masked", lows, 0);
      chk("ch2 hiz", drive_oe_n_ch2, !rows[i].ch);
    end
    $display("test modes done");
    @(posedge clock);
    sense_below_uv_fall <= 1'b1;
    repeat (8) @(negedge clock);
    chk("uv trip", drive_oe_n_ch1, 1'b1);
    chk("uv pg", power_good_oe_n, 1'b0);
    @(posedge clock);
    sense_below_uv_fall <= 1'b0;
    sense_above_uv_rise <= 1'b1;
    cycle_en();
    chk("uv restart", drive_oe_n_ch1, 1'b0);
    @(posedge clock);
    sense_above_uv_rise <= 1'b0;
    overcurrent_trip <= 1'b1;
    repeat (8) @(negedge clock);
    chk("oc trip", drive_oe_n_ch1, 1'b1);
    chk("ls off", {low_side_drive_ch1, low_side_drive_ch2}, 2'h0);
    @(posedge clock);
    overcurrent_trip <= 1'b0;
    cycle_en();
    chk("oc restart", drive_oe_n_ch1, 1'b0);
    @(posedge clock);
    sense_above_ov <= 1'b1;
    repeat (5) @(posedge clock);
    sense_above_ov <= 1'b0;
    cycle_en();
    chk("ov latch", drive_oe_n_ch1, 1'b1);
    axr(ADDR_STATUS);
    chk("ov flag", d[ST_OV], 1'b1);
    @(posedge clock);
    supply_above_rising <= 1'b0;
    supply_below_falling <= 1'b1;
    repeat (6) @(negedge clock);
    axr(ADDR_STATUS);
    chk("por ok", d[ST_POR_OK], 1'b0);
    @(posedge clock);
    supply_below_falling <= 1'b0;
    supply_above_rising <= 1'b1;
    repeat (10) @(negedge clock);
    chk("por restart", drive_oe_n_ch1, 1'b0);
    $display("test faults done");
    axw(ADDR_CTRL, 32'h0);
    chk("bresp", r, RESP_OKAY);
    repeat (6) @(negedge clock);
    chk("sw off", drive_oe_n_ch1, 1'b1);
    axr(ADDR_CTRL);
    chk("ctrl", d, 32'h0);
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk("reset ref", reference_code, REF_START);
    axr(ADDR_CTRL);
    chk("ctrl", d, CTRL_RESET);
    $display("test registers done");
    print_verdict();
  end
endmodule : tb
